// File: verilog/rwc_map.svh
// constants for the ram write checksum block
// assumes inclusion by the package and the top module
`ifndef RWC_MAP_SVH
`define RWC_MAP_SVH
// checksum register reset value
`define RWC_SUM_RESET 8'h00
// ram data stream byte and read data reset values
`define RWC_FIELD_RESET 8'h00
`define RWC_RDATA_RESET 32'h0000_0000
// crc-8 generator x^8 + x^5 + x^4 + 1, top term implied
`define RWC_CRC_POLY 8'h31
// register select code marking ram data bytes
`define RWC_RS_RAM_DATA 2'h1
// avalon register word addresses (byte address = index * 4)
`define RWC_ADDR_CTRL 2'h0
`define RWC_ADDR_CMD 2'h1
`define RWC_ADDR_DATA 2'h2
`define RWC_ADDR_SUM 2'h3
// control register bit positions
`define RWC_CTRL_MODE_BIT 0
// command select register fields
`define RWC_CMD_RS_LSB 0
`define RWC_CMD_RW_BIT 2
`endif

// File: verilog/rwc_pkg.sv
// types for the ram write checksum block
// assumes rwc_map.svh is on the include path
package rwc_pkg;
  `include "rwc_map.svh"
  // command select: register select field and read/write direction
  typedef struct packed {
    logic read_write;
    logic [1:0] register_select_field;
  } rwc_cmd_sel_t;
  // avalon request as carried into the slave
  typedef struct packed {
    logic read;
    logic write;
    logic [1:0] address;
    logic [31:0] writedata;
  } rwc_req_t;
endpackage

// File: verilog/rwc_checksum.sv
// ram write checksum: folds ram data bytes into an xor or crc-8 sum
// assumes a single avalon-mm master on clk_sys, the host link decoded upstream
// What this block does
// - checksum is xor when mode select is 0, crc-8 when 1
// - mode select is set by software before the checked transfer starts
// - xor mode: each ram data byte xored into the checksum
// - crc-8 mode: each byte updates checksum with poly x8+x5+x4+1
// - checksum clears whenever register select or read/write changes
// - current checksum is readable for host comparison
// - full 8-bit write byte accepted for display data ram writes
module rwc_checksum
  import rwc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // ram data stream toward the display data ram
  output logic [7:0] write_byte_field,
  output logic write_byte_valid
);

  // ************************************************************
  // bus handshake
  // ************************************************************
  rwc_req_t req;
  logic ack_reg;
  logic wr_go;
  logic rd_go;

  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata};
  // one wait state per access keeps read data registered
  assign avs_waitrequest = (req.read | req.write) & ~ack_reg;
  assign wr_go = req.write & ~ack_reg;
  assign rd_go = req.read & ~ack_reg;

  // ack lasts one cycle, so a held request is taken again every second cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (req.read | req.write) & ~ack_reg;
    end
  end

  // ************************************************************
  // address decode
  // ************************************************************
  logic lane0_on;
  logic sel_ctrl;
  logic sel_cmd;
  logic sel_data;
  logic ctrl_wr;
  logic cmd_wr;
  logic data_wr;

  // only the low byte lane carries anything; other lanes are ignored
  assign lane0_on = avs_byteenable[0];
  assign sel_ctrl = (req.address == `RWC_ADDR_CTRL);
  assign sel_cmd = (req.address == `RWC_ADDR_CMD);
  assign sel_data = (req.address == `RWC_ADDR_DATA);
  // writes to the sum word land nowhere: it is read only
  assign ctrl_wr = wr_go & sel_ctrl & lane0_on;
  assign cmd_wr = wr_go & sel_cmd & lane0_on;
  assign data_wr = wr_go & sel_data & lane0_on;

  // ************************************************************
  // checksum mode
  // ************************************************************
  logic checksum_mode_select;

  // a mode change leaves the sum alone; set it before the transfer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      checksum_mode_select <= 1'b0;
    end else if (ctrl_wr) begin
      checksum_mode_select <= req.writedata[`RWC_CTRL_MODE_BIT];
    end
  end

  // ************************************************************
  // command select
  // ************************************************************
  rwc_cmd_sel_t cmd_reg;
  rwc_cmd_sel_t cmd_next;
  logic rs_changed;
  logic rw_changed;
  logic cmd_changed;

  always_comb begin
    cmd_next = cmd_reg;
    if (cmd_wr) begin
      cmd_next.register_select_field = req.writedata[`RWC_CMD_RS_LSB +: 2];
      cmd_next.read_write = req.writedata[`RWC_CMD_RW_BIT];
    end
  end

  // rewriting the same value is no change and keeps the running sum
  assign rs_changed = (cmd_next.register_select_field != cmd_reg.register_select_field);
  assign rw_changed = (cmd_next.read_write != cmd_reg.read_write);
  assign cmd_changed = rs_changed | rw_changed;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  // ************************************************************
  // crc fold
  // ************************************************************
  logic [7:0] data_byte;
  logic [7:0] sum_reg;
  logic [7:0] crc_stage [0:8];

  assign data_byte = req.writedata[7:0];
  // eight unrolled stages, msb first, so a byte folds in one cycle
  // the top term of the poly is implied by the bit shifted out
  assign crc_stage[0] = sum_reg ^ data_byte;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_crc
      logic fb;
      logic [7:0] shifted;
      assign fb = crc_stage[gi][7];
      assign shifted = {crc_stage[gi][6:0], 1'b0};
      assign crc_stage[gi+1] = fb ? (shifted ^ `RWC_CRC_POLY) : shifted;
    end
  endgenerate

  // ************************************************************
  // checksum
  // ************************************************************
  logic ram_target;
  logic data_take;
  logic [7:0] xor_fold;
  logic [7:0] sum_next;

  // only ram data writes in write direction feed the sum; others ignored
  assign ram_target = (cmd_reg.register_select_field == `RWC_RS_RAM_DATA)
                      && !cmd_reg.read_write;
  assign data_take = data_wr & ram_target;
  assign xor_fold = sum_reg ^ data_byte;

  always_comb begin
    sum_next = sum_reg;
    if (data_take) begin
      if (checksum_mode_select) begin
        sum_next = crc_stage[8];
      end else begin
        sum_next = xor_fold;
      end
    end
  end

  // a clear and a data byte never meet: accesses are serial on the bus
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sum_reg <= `RWC_SUM_RESET;
    end else if (cmd_changed) begin
      sum_reg <= `RWC_SUM_RESET;
    end else begin
      sum_reg <= sum_next;
    end
  end

  // ************************************************************
  // ram data stream
  // ************************************************************
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      write_byte_valid <= 1'b0;
    end else begin
      write_byte_valid <= data_take;
    end
  end

  // the field holds the last byte, so a read of the data word shows it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      write_byte_field <= `RWC_FIELD_RESET;
    end else if (data_take) begin
      write_byte_field <= data_byte;
    end
  end

  // ************************************************************
  // read back
  // ************************************************************
  logic [31:0] rd_word;

  always_comb begin
    rd_word = `RWC_RDATA_RESET;
    unique case (req.address)
      `RWC_ADDR_CTRL: rd_word = {31'h0, checksum_mode_select};
      `RWC_ADDR_CMD: rd_word = {29'h0, cmd_reg.read_write, cmd_reg.register_select_field};
      `RWC_ADDR_DATA: rd_word = {24'h0, write_byte_field};
      `RWC_ADDR_SUM: rd_word = {24'h0, sum_reg};
    endcase
  end

  // registered so read data never ripples straight off the address lines
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      avs_readdata <= `RWC_RDATA_RESET;
    end else if (rd_go) begin
      avs_readdata <= rd_word;
    end
  end

endmodule // rwc_checksum

// File: tb/rwc_checker.sv
// port checker for rwc_checksum
// assumes it is bound onto every rwc_checksum
module rwc_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic [7:0] write_byte_field,
  input wire logic write_byte_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire logic req = avs_read || avs_write;
  wire logic take = avs_write && avs_waitrequest && avs_address == 2'h2 && avs_byteenable[0];
  chk_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("late ack");
  chk_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("idle wait");
  chk_wait_new: assert property ($rose(req) |-> avs_waitrequest)
    else $error("early ack");
  chk_byte_cause: assert property (write_byte_valid |-> $past(take))
    else $error("stray byte");
  chk_byte_pulse: assert property (write_byte_valid |=> !write_byte_valid)
    else $error("long pulse");
  chk_byte_value: assert property (write_byte_valid |->
    {24'h0, write_byte_field} == ($past(avs_writedata) & 32'hFF)) else $error("bad byte");
  chk_lane_off: assert property (take == 1'h0 && avs_write && avs_waitrequest
    && avs_address == 2'h2 |=> !write_byte_valid) else $error("lane ignored");
  chk_byte_hold: assert property (!write_byte_valid |-> $stable(write_byte_field))
    else $error("byte moved");
endmodule // rwc_checker
bind rwc_checksum rwc_checker chk_u (.*);

// File: tb/rwc_host.sv
// host model: avalon master toward rwc_checksum
// assumes one call at a time, entered just after a clock edge
module rwc_host
  import rwc_pkg::*;
(
  // bus
  input wire logic clk_sys,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output rwc_req_t req,
  output logic [3:0] be
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req = '0;
  initial be = 4'h0;
  // released lines flip, so a stale value can never pass as fresh
  task automatic acc(input logic rd, input logic [1:0] a, input logic [31:0] d,
      input logic [3:0] b, output logic [31:0] q);
    logic w;
    req <= '{rd, !rd, a, d};
    be <= b;
    do begin
      @(posedge clk_sys);
      w = avs_waitrequest;
      q = avs_readdata;
    end while (w !== 1'h0);
    req <= '{1'h0, 1'h0, ~a, ~d};
    be <= ~b;
    @(posedge clk_sys);
  endtask
endmodule // rwc_host

// File: tb/tb.sv
// self-checking bench for rwc_checksum
// assumes rwc_host as software side, checker bound in
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  `include "rwc_map.svh"
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  rwc_pkg::rwc_req_t req;
  logic [3:0] be;
  logic [31:0] rd;
  logic wt;
  logic [31:0] q;
  logic [7:0] e;
  logic [7:0] bytes [3] = '{8'h01, 8'hA5, 8'hFF};
  int n_mismatch = 0;
  int compares = 0;
  always #5 clk_sys = ~clk_sys;
  rwc_checksum dut_u (.clk_sys(clk_sys), .reset(reset), .avs_address(req.address),
    .avs_read(req.read), .avs_write(req.write), .avs_writedata(req.writedata),
    .avs_byteenable(be), .avs_readdata(rd), .avs_waitrequest(wt),
    .write_byte_field(), .write_byte_valid());
  rwc_host host_u (.clk_sys(clk_sys), .avs_waitrequest(wt), .avs_readdata(rd),
    .req(req), .be(be));
  function automatic logic [7:0] crc(input logic [7:0] s, input logic [7:0] b);
    s = s ^ b;
    for (int i = 0; i < 8; i++) s = s[7] ? (s << 1) ^ 8'h31 : s << 1;
    return s;
  endfunction
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    host_u.acc(1'h0, a, {24'h0, d}, 4'h1, q);
  endtask
  task automatic chk(input logic [1:0] a, input logic [7:0] x);
    host_u.acc(1'h1, a, 32'h0, 4'hF, q);
    compares++;
    if (q[7:0] !== x) begin
      n_mismatch++;
      $display("ERROR %0t read %h want %h", $time, q[7:0], x);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_sys);
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    chk(`RWC_ADDR_SUM, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(`RWC_ADDR_CTRL, 8'(m));
      chk(`RWC_ADDR_CTRL, 8'(m));
      wr(`RWC_ADDR_CMD, 8'h0);
      wr(`RWC_ADDR_CMD, 8'h1);
      chk(`RWC_ADDR_CMD, 8'h1);
      e = 8'h00;
      foreach (bytes[i]) begin
        wr(`RWC_ADDR_DATA, bytes[i]);
        e = m ? crc(e, bytes[i]) : e ^ bytes[i];
      end
      chk(`RWC_ADDR_DATA, bytes[2]);
      wr(`RWC_ADDR_CMD, 8'h1);
      host_u.acc(1'h0, `RWC_ADDR_DATA, 32'h77, 4'h0, q);
      chk(`RWC_ADDR_SUM, e);
      wr(`RWC_ADDR_CMD, 8'h5);
      chk(`RWC_ADDR_SUM, 8'h00);
      wr(`RWC_ADDR_DATA, 8'h3C);
      chk(`RWC_ADDR_SUM, 8'h00);
      chk(`RWC_ADDR_DATA, bytes[2]);
    end
    end_sim;
  end
endmodule // tb
